// *** rtl/dtl_timer.v ***
// Dual timebase lite timer: two 8-bit timebase counters, an 8-bit input capture,
// one shared interrupt request and five byte registers on an APB slave.
// Assumes pclk is the oscillator clock, and that halt_mode and irq_mask come
// synchronous from the power and interrupt controllers of the chip.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "dtl_defines.vh"

module dtl_timer #(
    parameter ADDR_W = 8
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output wire [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              halt_mode,
    input  wire              irq_mask,
    input  wire              capture_input_pin,
    output wire              irq
);

    // Control and status state.
    reg               second_tick_irq_enable_r;
    reg               second_tick_flag_r;
    reg  [7:0]        reload_bits_r;
    reg  [7:0]        count_bits_r;
    reg               capture_irq_enable_r;
    reg               capture_flag_r;
    reg               tick_period_double_r;
    reg               first_tick_irq_enable_r;
    reg               first_tick_flag_r;
    reg  [7:0]        capture_bits_r;
    reg  [7:0]        cnt1_r;
    reg               half_r;
    reg  [31:0]       prdata_r;
    reg               seen_second_tick_flag_r;
    reg               seen_first_tick_flag_r;
    reg               seen_icf_r;

    // Next values.
    reg               second_tick_flag_nxt;
    reg               first_tick_flag_nxt;
    reg               capture_flag_nxt;
    reg  [7:0]        capture_bits_nxt;
    reg  [7:0]        count_bits_nxt;
    reg  [7:0]        cnt1_nxt;
    reg               half_nxt;
    reg  [31:0]       prdata_nxt;

    wire              osc_tick;
    wire              cap_edge;
    wire              setup_ph;
    wire              access_ph;
    wire              mapped;
    wire              wr_en;
    wire              rd_en;
    wire              sel_tb2_csr;
    wire              sel_reload;
    wire              sel_cnt2;
    wire              sel_tb1_csr;
    wire              sel_capture;
    wire              cnt1_wrap;
    wire              cnt2_wrap;
    wire              tb1_event;
    wire [7:0]        tb2_csr_view;
    wire [7:0]        tb1_csr_view;

    // Compares the bus address against a register's byte address.
    function hit;
        input [ADDR_W-1:0] a;
        input [7:0]        reg_addr;
        begin
            hit = (a == reg_addr[ADDR_W-1:0]);
        end
    endfunction

    // Places an 8-bit register in the low byte of a bus word.
    function [31:0] word_of;
        input [7:0] b;
        begin
            word_of = {24'h00_0000, b};
        end
    endfunction

    dtl_prescaler #(
        .DIV (`DTL_OSC_DIV)
    ) u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (!halt_mode),
        .tick    (osc_tick)
    );

    dtl_edge_sync u_edge_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (capture_input_pin),
        .edge_pulse (cap_edge)
    );

    // The slave answers with no wait state: every access phase completes.
    assign setup_ph    = psel && !penable;
    assign access_ph   = psel && penable;
    assign pready      = 1'b1;
    assign prdata      = prdata_r;

    assign sel_tb2_csr = hit(paddr, `DTL_ADDR_TB2_CSR);
    assign sel_reload  = hit(paddr, `DTL_ADDR_RELOAD);
    assign sel_cnt2    = hit(paddr, `DTL_ADDR_CNT2);
    assign sel_tb1_csr = hit(paddr, `DTL_ADDR_TB1_CSR);
    assign sel_capture = hit(paddr, `DTL_ADDR_CAPTURE);
    assign mapped      = sel_tb2_csr | sel_reload | sel_cnt2 | sel_tb1_csr | sel_capture;

    assign pslverr     = access_ph && !mapped;
    assign wr_en       = access_ph && pwrite && mapped;
    assign rd_en       = access_ph && !pwrite && mapped;

    assign tb2_csr_view = {6'b00_0000, second_tick_irq_enable_r, second_tick_flag_r};
    assign tb1_csr_view = {capture_irq_enable_r, capture_flag_r, tick_period_double_r,
                           first_tick_irq_enable_r, first_tick_flag_r, 3'b000};

    assign cnt1_wrap = osc_tick && (cnt1_r == `DTL_CNT1_LAST);
    // doubled period on every second wrap
    assign tb1_event = cnt1_wrap && (!tick_period_double_r || half_r);
    assign cnt2_wrap = osc_tick && (count_bits_r == `DTL_CNT2_LAST);

    assign irq = !irq_mask && ((second_tick_flag_r && second_tick_irq_enable_r) ||
                               (first_tick_flag_r && first_tick_irq_enable_r) ||
                               (capture_flag_r && capture_irq_enable_r));

    // Read data is built in the setup phase, so it stands from a flip-flop
    // for the whole access phase.
    always @*
    begin
        prdata_nxt = prdata_r;
        if (setup_ph)
        begin
            if (pwrite)
            begin
                prdata_nxt = `DTL_RST_WORD;
            end
            else if (sel_tb2_csr)
            begin
                prdata_nxt = word_of(tb2_csr_view);
            end
            else if (sel_reload)
            begin
                prdata_nxt = word_of(reload_bits_r);
            end
            else if (sel_cnt2)
            begin
                prdata_nxt = word_of(count_bits_r);
            end
            else if (sel_tb1_csr)
            begin
                prdata_nxt = word_of(tb1_csr_view);
            end
            else if (sel_capture)
            begin
                prdata_nxt = word_of(capture_bits_r);
            end
            else
            begin
                prdata_nxt = `DTL_RST_WORD;
            end
        end
    end

    // Counters and the capture path.
    always @*
    begin
        cnt1_nxt         = cnt1_r;
        half_nxt         = half_r;
        count_bits_nxt   = count_bits_r;
        capture_bits_nxt = capture_bits_r;
        if (osc_tick)
        begin
            if (cnt1_wrap)
            begin
                cnt1_nxt = 8'h00;
                half_nxt = !half_r;
            end
            else
            begin
                cnt1_nxt = cnt1_r + 8'h01;
            end
            if (cnt2_wrap)
            begin
                count_bits_nxt = reload_bits_r;
            end
            else
            begin
                count_bits_nxt = count_bits_r + 8'h01;
            end
        end
        // latch counter 1 on either edge while the capture flag is clear
        if (cap_edge && !capture_flag_r)
        begin
            capture_bits_nxt = cnt1_r;
        end
    end

    // Flags: a read clears only a flag that was set in the read's setup phase,
    // and a new timebase event in the clearing cycle keeps its flag set; a capture edge then is lost.
    always @*
    begin
        second_tick_flag_nxt = cnt2_wrap ||
            (second_tick_flag_r && !(rd_en && sel_tb2_csr && seen_second_tick_flag_r));
        first_tick_flag_nxt = tb1_event ||
            (first_tick_flag_r && !(rd_en && sel_tb1_csr && seen_first_tick_flag_r));
        // set on capture, capture read clears
        capture_flag_nxt = (cap_edge && !capture_flag_r) ||
            (capture_flag_r && !(rd_en && sel_capture && seen_icf_r));
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_tick_flag_r <= 1'b0;
            first_tick_flag_r  <= 1'b0;
            // The flag is cleared here although software may not rely on it.
            capture_flag_r     <= 1'b0;
            capture_bits_r     <= `DTL_RST_BYTE;
            cnt1_r             <= `DTL_RST_BYTE;
            half_r             <= 1'b0;
            count_bits_r       <= `DTL_RST_BYTE;
            prdata_r           <= `DTL_RST_WORD;
            seen_second_tick_flag_r        <= 1'b0;
            seen_first_tick_flag_r        <= 1'b0;
            seen_icf_r         <= 1'b0;
        end
        else
        begin
            second_tick_flag_r <= second_tick_flag_nxt;
            first_tick_flag_r  <= first_tick_flag_nxt;
            capture_flag_r     <= capture_flag_nxt;
            capture_bits_r     <= capture_bits_nxt;
            cnt1_r             <= cnt1_nxt;
            half_r             <= half_nxt;
            count_bits_r       <= count_bits_nxt;
            prdata_r           <= prdata_nxt;
            if (setup_ph)
            begin
                seen_second_tick_flag_r <= second_tick_flag_r;
                seen_first_tick_flag_r <= first_tick_flag_r;
                seen_icf_r  <= capture_flag_r;
            end
        end
    end

    // Software-written control bits; flag and count bits ignore writes.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_tick_irq_enable_r <= 1'b0;
            reload_bits_r            <= `DTL_RST_BYTE;
            capture_irq_enable_r     <= 1'b0;
            tick_period_double_r     <= 1'b0;
            first_tick_irq_enable_r  <= 1'b0;
        end
        else if (wr_en)
        begin
            if (sel_tb2_csr)
            begin
                second_tick_irq_enable_r <= pwdata[`DTL_TB2_IE_BIT];
            end
            if (sel_reload)
            begin
                reload_bits_r <= pwdata[7:0];
            end
            if (sel_tb1_csr)
            begin
                capture_irq_enable_r    <= pwdata[`DTL_CAP_IE_BIT];
                tick_period_double_r    <= pwdata[`DTL_PERIOD_DBL_BIT];
                first_tick_irq_enable_r <= pwdata[`DTL_TB1_IE_BIT];
            end
        end
    end

endmodule // dtl_timer

// *** rtl/dtl_defines.vh ***
// Register map, field positions, reset values and counts of the dual timebase lite timer.
// Assumes a 32-bit APB slave in which each 8-bit register sits in the low byte of one word.
`ifndef DTL_DEFINES_VH
`define DTL_DEFINES_VH

// Register indices and their byte addresses, four times the index.
`define DTL_IDX_TB2_CSR       8'h0C
`define DTL_IDX_RELOAD        8'h0D
`define DTL_IDX_CNT2          8'h0E
`define DTL_IDX_TB1_CSR       8'h0F
`define DTL_IDX_CAPTURE       8'h10
`define DTL_ADDR_TB2_CSR      8'h30
`define DTL_ADDR_RELOAD       8'h34
`define DTL_ADDR_CNT2         8'h38
`define DTL_ADDR_TB1_CSR      8'h3C
`define DTL_ADDR_CAPTURE      8'h40

// Second control/status register fields.
`define DTL_TB2_IE_BIT        1
`define DTL_TB2_FLAG_BIT      0

// First control/status register fields.
`define DTL_CAP_IE_BIT        7
`define DTL_CAP_FLAG_BIT      6
`define DTL_PERIOD_DBL_BIT    5
`define DTL_TB1_IE_BIT        4
`define DTL_TB1_FLAG_BIT      3

// Reset values.
`define DTL_RST_BYTE          8'h00
`define DTL_RST_WORD          32'h0000_0000

// Counting: the oscillator divider and the last values of both counters.
`define DTL_OSC_DIV           32
`define DTL_CNT1_LAST         8'hF9
`define DTL_CNT2_LAST         8'hFF

`endif

// *** rtl/dtl_prescaler.v ***
// Divider that turns the oscillator clock into a one-cycle tick every DIV cycles.
// Assumes pclk is the oscillator clock; run low freezes the divider where it stands.
`timescale 1ns/1ps
`include "dtl_defines.vh"

module dtl_prescaler #(
    parameter DIV = `DTL_OSC_DIV
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       run,
    output wire       tick
);

    // The divider is five bits wide, so only the low bits of DIV - 1 are kept.
    localparam [31:0] LAST_FULL = DIV - 1;
    localparam [4:0]  LAST      = LAST_FULL[4:0];

    reg  [4:0]        div_r;

    assign tick = run && (div_r == LAST);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r <= 5'h00;
        end
        else if (run)
        begin
            if (div_r == LAST)
            begin
                div_r <= 5'h00;
            end
            else
            begin
                div_r <= div_r + 5'h01;
            end
        end
    end

endmodule // dtl_prescaler

// *** rtl/dtl_edge_sync.v ***
// Two-stage synchroniser and both-edge detector for the capture input pin.
// Assumes the pin is asynchronous; edge pulses come two cycles after the pin moves.
`timescale 1ns/1ps

module dtl_edge_sync (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       pin,
    output wire       edge_pulse
);

    reg               sync1_r;
    reg               sync2_r;
    reg               prev_r;
    reg  [2:0]        primed_r;

    // Edges are held off until the history is filled, so a pin that is high
    // at reset does not look like a rising edge.
    assign edge_pulse = primed_r[2] && (sync2_r != prev_r);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r  <= 1'b0;
            sync2_r  <= 1'b0;
            prev_r   <= 1'b0;
            primed_r <= 3'b000;
        end
        else
        begin
            sync1_r  <= pin;
            sync2_r  <= sync1_r;
            prev_r   <= sync2_r;
            primed_r <= {primed_r[1:0], 1'b1};
        end
    end

endmodule // dtl_edge_sync

// *** sim/dtl_timer_assertions.sv ***
// Checker for the timer's register bus, read-back and interrupt gating.
// Assumes it is bound to dtl_timer and sees only that module's ports.
`timescale 1ns/1ps
`include "dtl_defines.vh"

module dtl_timer_chk #(
    parameter ADDR_W = 8
) (
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    input wire              halt_mode,
    input wire              irq_mask,
    input wire              capture_input_pin,
    input wire              irq
);
    // Shadows of the reload and control bits software wrote; flags cannot be mirrored from ports.
    reg  [7:0] rel_r;
    reg  [2:0] ctl1_r;
    reg        ie2_r;
    wire       wr_acc = psel && penable && pwrite;
    wire       map_ok = paddr == `DTL_ADDR_TB2_CSR || paddr == `DTL_ADDR_RELOAD ||
                        paddr == `DTL_ADDR_CNT2 || paddr == `DTL_ADDR_TB1_CSR ||
                        paddr == `DTL_ADDR_CAPTURE;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rel_r  <= 8'h00;
            ctl1_r <= 3'b000;
            ie2_r  <= 1'b0;
        end
        else if (wr_acc)
        begin
            if (paddr == `DTL_ADDR_RELOAD)
                rel_r <= pwdata[7:0];
            if (paddr == `DTL_ADDR_TB1_CSR)
                ctl1_r <= {pwdata[7], pwdata[5:4]};
            if (paddr == `DTL_ADDR_TB2_CSR)
                ie2_r <= pwdata[1];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rd_acc(a);
        psel && penable && !pwrite && paddr == a;
    endsequence

    err_unmapped_a: assert property (pslverr == (psel && penable && !map_ok))
        else $error("pslverr wrong");
    upper_zero_a: assert property (prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    unmapped_zero_a: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    ready_high_a: assert property (pready)
        else $error("pready low");
    tb1_reserved_a: assert property (rd_acc(`DTL_ADDR_TB1_CSR) |-> prdata[2:0] == 3'h0)
        else $error("reserved bits set");
    reload_rdback_a: assert property (rd_acc(`DTL_ADDR_RELOAD) |-> prdata[7:0] == rel_r)
        else $error("reload read-back wrong");
    tb2_ie_rdback_a: assert property (rd_acc(`DTL_ADDR_TB2_CSR) |-> prdata[1] == ie2_r)
        else $error("second enable read-back wrong");
    tb1_ctrl_rdback_a: assert property (rd_acc(`DTL_ADDR_TB1_CSR) |->
        {prdata[7], prdata[5:4]} == ctl1_r)
        else $error("first control read-back wrong");
    irq_masked_a: assert property (irq_mask |-> !irq)
        else $error("irq while masked");
    irq_gated_a: assert property (!(ie2_r || ctl1_r[2] || ctl1_r[0]) |-> !irq)
        else $error("irq with no enable");
endmodule // dtl_timer_chk

bind dtl_timer dtl_timer_chk #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_mode(halt_mode), .irq_mask(irq_mask), .capture_input_pin(capture_input_pin),
    .irq(irq)
);

// *** sim/dtl_pin_src.sv ***
// Model of the signal source on the capture input pin.
// Assumes the bench raises req for one clock; the pin toggles one or two clocks later.
`timescale 1ns/1ps

module dtl_pin_src (
    input  wire  pclk,
    input  wire  req,
    input  wire  slow,
    output logic pin
);
    logic late_r = 1'b0;

    initial pin = 1'b0;
    // A slow source answers one clock later, which moves the capture by one cycle.
    always @(posedge pclk)
    begin
        late_r <= req && slow;
        if ((req && !slow) || late_r)
            pin <= ~pin;
    end
endmodule // dtl_pin_src

// *** sim/test_dual_timebase_lite_timer.sv ***
// Self-checking bench for dtl_timer: registers, both counters, halt and capture.
// Assumes dtl_pin_src drives the capture pin and the checker is bound in.
`timescale 1ns/1ps
`include "dtl_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %0h expected %0h", $time, (g), (e)); end end

module test_dual_timebase_lite_timer;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        halt_mode = 0, irq_mask = 0, req = 0, slow = 0, err;
    logic [7:0]  paddr = 0, r, k;
    logic [31:0] pwdata = 0, rd, v, seed = 32'h49f3;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, pin;
    int          failures = 0, comparisons = 0, cyc = 0, t0, t1;

    dtl_timer #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
        .irq_mask(irq_mask), .capture_input_pin(pin), .irq(irq));
    dtl_pin_src u_pin (.pclk(pclk), .req(req), .slow(slow), .pin(pin));

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends this wait, so a stretched access phase is still served.
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // At least one edge passes first, so a flag cleared at the caller's last edge is not
    // seen again; the task returns on an edge, so the caller drives on the clock again.
    task automatic wait_irq(input int lim, output int t);
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        while (irq !== 1'b1 && n < lim);
        t = cyc;
        `CHK(irq, 1'b1)
        @(posedge pclk);
    endtask

    task automatic report_and_stop;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // every register and one unmapped address read once after reset
        for (int i = 0; i < 6; i++)
        begin
            apb(0, 8'h30 + 8'(4 * i), 0);
            `CHK(rd, 32'h0000_0000)
            `CHK(err, i == 5)
        end
        apb(1, `DTL_ADDR_RELOAD, 32'h0000_00F0);
        apb(1, `DTL_ADDR_TB2_CSR, 32'h0000_0003);
        apb(0, `DTL_ADDR_TB2_CSR, 0);
        `CHK(rd, 32'h0000_0002)
        halt_mode <= 1'b1;
        apb(0, `DTL_ADDR_CNT2, 0);
        v = rd;
        seed = lfsr(seed);
        apb(1, `DTL_ADDR_CNT2, seed);
        apb(0, `DTL_ADDR_CNT2, 0);
        `CHK(rd, v)
        halt_mode <= 1'b0;
        wait_irq(9000, t0);
        apb(0, `DTL_ADDR_TB2_CSR, 0);
        `CHK(rd, 32'h0000_0003)
        apb(0, `DTL_ADDR_TB2_CSR, 0);
        `CHK(rd, 32'h0000_0002)
        wait_irq(600, t1);
        `CHK(t1 - t0, 512)
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(lfsr(seed));
            r = (i == 0) ? 8'hFF : 8'hE0 | seed[4:0];
            apb(0, `DTL_ADDR_TB2_CSR, 0);
            apb(1, `DTL_ADDR_RELOAD, {24'h00_0000, r});
            wait_irq(1100, t0);
            apb(0, `DTL_ADDR_TB2_CSR, 0);
            wait_irq(1100, t1);
            `CHK(t1 - t0, (256 - r) * 32)
        end
        irq_mask <= 1'b1;
        apb(0, `DTL_ADDR_TB2_CSR, 0);
        repeat (1100) @(posedge pclk);
        `CHK(irq, 1'b0)
        irq_mask <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK(irq, 1'b1)
        // The flag is still set here, so only the cleared enable can lower irq.
        apb(1, `DTL_ADDR_TB2_CSR, 0);
        @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(0, `DTL_ADDR_TB2_CSR, 0);
        `CHK(rd, 32'h0000_0001)
        apb(1, `DTL_ADDR_TB1_CSR, 32'h0000_0010);
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        wait_irq(8100, t0);
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        `CHK(rd, 32'h0000_0018)
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        `CHK(rd, 32'h0000_0010)
        halt_mode <= 1'b1;
        repeat (100) @(posedge pclk);
        halt_mode <= 1'b0;
        wait_irq(8200, t1);
        `CHK(t1 - t0, 8100)
        apb(1, `DTL_ADDR_TB1_CSR, 32'h0000_0030);
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        wait_irq(16100, t0);
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        wait_irq(16100, t1);
        `CHK(t1 - t0, 16000)
        apb(1, `DTL_ADDR_TB1_CSR, 32'h0000_0010);
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        wait_irq(8100, t0);
        apb(1, `DTL_ADDR_TB1_CSR, 32'h0000_00C0);
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        `CHK(rd[6], 1'b0)
        seed = lfsr(lfsr(seed));
        k = 8'(1 + seed[7:0] % 200);
        slow <= seed[8];
        while (cyc < t0 + k * 32 + 14)
            @(posedge pclk);
        req <= 1'b1;
        @(posedge pclk);
        req <= 1'b0;
        wait_irq(8, t1);
        // A second edge while the flag is set lands one count later, or two with a slow source, and must be lost.
        repeat (40) @(posedge pclk);
        req <= 1'b1;
        @(posedge pclk);
        req <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        `CHK(rd[6], 1'b1)
        apb(0, `DTL_ADDR_CAPTURE, 0);
        `CHK(rd, {24'h00_0000, k})
        apb(0, `DTL_ADDR_TB1_CSR, 0);
        `CHK(rd[6], 1'b0)
        report_and_stop();
    end

    initial
    begin
        repeat (100000) @(posedge pclk);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule // test_dual_timebase_lite_timer
